// ### design/amp_defines.svh
`ifndef AMP_DEFINES_SVH
`define AMP_DEFINES_SVH
`define AMP_ADDR_POLARITY 8'h16
`define AMP_ADDR_LOS_MASK 8'h17
`define AMP_ADDR_FOS_MASK 8'h18
`define AMP_ADDR_FAST_DIV 8'h19
`define AMP_RST_POLARITY 8'hdf
`define AMP_RST_LOS_MASK 8'h1f
`define AMP_RST_FOS_MASK 8'h3f
`define AMP_RST_FAST_DIV 8'h20
`define AMP_POL_ACTIVE_BIT 3
`define AMP_POL_BAD_BIT 2
`define AMP_POL_UNLOCK_BIT 1
`define AMP_POL_IRQ_BIT 0
`define AMP_DIV_SEL_MSB 7
`define AMP_DIV_SEL_LSB 5
`define AMP_DIV_BASE 4'h4
`define AMP_POL_RO_MASK 8'hf0
`define AMP_LOS_RO_MASK 8'hf8
`define AMP_DIV_RO_MASK 8'h1f
`define AMP_FOS_RO_MASK 8'hf8
`define AMP_MSK_IN2_BIT 2
`define AMP_MSK_IN1_BIT 1
`define AMP_MSK_XTAL_BIT 0
`define AMP_MSK_UNLOCK_BIT 0
`endif

// ### design/amp_pkg.sv
package amp_pkg;
    typedef logic [7:0] amp_byte_t;
    typedef logic [2:0] amp_div_sel_t;
    typedef logic [3:0] amp_ratio_t;
endpackage

// ### design/amp_fast_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "amp_defines.svh"
// --------------------------------------------------------------
// Fast output divider feeding both slow output dividers
// --------------------------------------------------------------
module amp_fast_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire amp_pkg::amp_div_sel_t output_fast_divide_select,
    // Divided clock enable pulses to the slow dividers
    output logic slow_div1_tick,
    output logic slow_div2_tick,
    output logic [3:0] fast_ratio
);
    logic [3:0] count_q;
    logic [3:0] ratio;
    assign ratio = `AMP_DIV_BASE + {1'b0, output_fast_divide_select};
    assign fast_ratio = ratio;
    always_ff @(posedge clk) begin
        if (reset || count_q >= ratio - 4'h1) begin
            count_q <= 4'h0;
        end else begin
            count_q <= count_q + 4'h1;
        end
    end
    // Both slow dividers see the same tick, so they stay phase aligned.
    always_ff @(posedge clk) begin
        if (reset) begin
            slow_div1_tick <= 1'b0;
            slow_div2_tick <= 1'b0;
        end else begin
            slow_div1_tick <= (count_q == ratio - 4'h1);
            slow_div2_tick <= (count_q == ratio - 4'h1);
        end
    end
endmodule
`default_nettype wire

// ### design/amp_alarm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "amp_defines.svh"
// --------------------------------------------------------------
// --------------------------------------------------------------
module amp_alarm_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire amp_pkg::amp_byte_t reg_addr,
    input wire amp_pkg::amp_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Sticky alarm flags, held elsewhere
    input wire logic in2_signal_loss_flag,
    input wire logic in1_signal_loss_flag,
    input wire logic xtal_signal_loss_flag,
    input wire logic in2_freq_offset_flag,
    input wire logic in1_freq_offset_flag,
    input wire logic unlock_flag,
    // Live status and pin routing controls
    input wire logic in1_bad_status,
    input wire logic in2_bad_status,
    input wire logic unlock_status,
    input wire logic active_input_status,
    input wire logic irq_route_enable,
    input wire logic in1_bad_route_enable,
    input wire logic in2_bad_route_enable,
    input wire logic unlock_route_enable,
    input wire logic active_route_enable,
    // Pins as output and enable pairs
    output logic irq_or_in1_bad_pin_o,
    output logic irq_or_in1_bad_pin_oe,
    output logic in2_bad_pin_o,
    output logic in2_bad_pin_oe,
    output logic unlock_pin_o,
    output logic unlock_pin_oe,
    output logic select_or_active_pin_o,
    output logic select_or_active_pin_oe,
    output logic irq_status,
    // Slow divider feed
    output logic slow_div1_tick,
    output logic slow_div2_tick
);
    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    amp_pkg::amp_byte_t alarm_pin_polarity_q;
    amp_pkg::amp_byte_t signal_loss_irq_mask_q;
    amp_pkg::amp_byte_t offset_lock_irq_mask_q;
    amp_pkg::amp_byte_t output_fast_divider_q;
    logic active_input_indicator_polarity;
    logic bad_input_indicator_polarity;
    logic unlock_indicator_polarity;
    logic irq_polarity;
    logic in2_signal_loss_mask;
    logic in1_signal_loss_mask;
    logic xtal_signal_loss_mask;
    logic in2_freq_offset_mask;
    logic in1_freq_offset_mask;
    logic unlock_mask;
    logic irq_d;
    logic [3:0] fast_ratio;

    // Read-only bits keep their reset value, so writes merge only writable bits.
    function automatic amp_pkg::amp_byte_t merge_write(input amp_pkg::amp_byte_t old_v,
                                                       input amp_pkg::amp_byte_t new_v,
                                                       input amp_pkg::amp_byte_t ro);
        merge_write = (old_v & ro) | (new_v & ~ro);
    endfunction

    function automatic logic drive_level(input logic active, input logic pol);
        drive_level = pol ? active : ~active;
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            alarm_pin_polarity_q <= `AMP_RST_POLARITY;
        end else if (reg_wr && reg_addr == `AMP_ADDR_POLARITY) begin
            alarm_pin_polarity_q <= merge_write(alarm_pin_polarity_q, reg_wdata,
                                                `AMP_POL_RO_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            signal_loss_irq_mask_q <= `AMP_RST_LOS_MASK;
        end else if (reg_wr && reg_addr == `AMP_ADDR_LOS_MASK) begin
            signal_loss_irq_mask_q <= merge_write(signal_loss_irq_mask_q, reg_wdata,
                                                  `AMP_LOS_RO_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offset_lock_irq_mask_q <= `AMP_RST_FOS_MASK;
        end else if (reg_wr && reg_addr == `AMP_ADDR_FOS_MASK) begin
            offset_lock_irq_mask_q <= merge_write(offset_lock_irq_mask_q, reg_wdata,
                                                  `AMP_FOS_RO_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            output_fast_divider_q <= `AMP_RST_FAST_DIV;
        end else if (reg_wr && reg_addr == `AMP_ADDR_FAST_DIV) begin
            output_fast_divider_q <= merge_write(output_fast_divider_q, reg_wdata,
                                                 `AMP_DIV_RO_MASK);
        end
    end

    // --------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            if (reg_addr == `AMP_ADDR_POLARITY) begin
                reg_rdata <= alarm_pin_polarity_q;
                reg_hit <= 1'b1;
            end else if (reg_addr == `AMP_ADDR_LOS_MASK) begin
                reg_rdata <= signal_loss_irq_mask_q;
                reg_hit <= 1'b1;
            end else if (reg_addr == `AMP_ADDR_FOS_MASK) begin
                reg_rdata <= offset_lock_irq_mask_q;
                reg_hit <= 1'b1;
            end else if (reg_addr == `AMP_ADDR_FAST_DIV) begin
                reg_rdata <= output_fast_divider_q;
                reg_hit <= 1'b1;
            end else begin
                reg_rdata <= 8'h00;
                reg_hit <= 1'b0;
            end
        end else begin
            reg_hit <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Interrupt combine
    // --------------------------------------------------------------
    assign active_input_indicator_polarity = alarm_pin_polarity_q[`AMP_POL_ACTIVE_BIT];
    assign bad_input_indicator_polarity = alarm_pin_polarity_q[`AMP_POL_BAD_BIT];
    assign unlock_indicator_polarity = alarm_pin_polarity_q[`AMP_POL_UNLOCK_BIT];
    assign irq_polarity = alarm_pin_polarity_q[`AMP_POL_IRQ_BIT];
    assign in2_signal_loss_mask = signal_loss_irq_mask_q[`AMP_MSK_IN2_BIT];
    assign in1_signal_loss_mask = signal_loss_irq_mask_q[`AMP_MSK_IN1_BIT];
    assign xtal_signal_loss_mask = signal_loss_irq_mask_q[`AMP_MSK_XTAL_BIT];
    assign in2_freq_offset_mask = offset_lock_irq_mask_q[`AMP_MSK_IN2_BIT];
    assign in1_freq_offset_mask = offset_lock_irq_mask_q[`AMP_MSK_IN1_BIT];
    assign unlock_mask = offset_lock_irq_mask_q[`AMP_MSK_UNLOCK_BIT];

    // Flags are only read here; they are stored outside, so masks cannot disturb them.
    assign irq_d = (in2_signal_loss_flag && !in2_signal_loss_mask)
                || (in1_signal_loss_flag && !in1_signal_loss_mask)
                || (xtal_signal_loss_flag && !xtal_signal_loss_mask)
                || (in2_freq_offset_flag && !in2_freq_offset_mask)
                || (in1_freq_offset_flag && !in1_freq_offset_mask)
                || (unlock_flag && !unlock_mask);

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_status <= 1'b0;
        end else begin
            irq_status <= irq_d;
        end
    end

    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_or_in1_bad_pin_o <= 1'b0;
            irq_or_in1_bad_pin_oe <= 1'b0;
        end else if (irq_route_enable) begin
            irq_or_in1_bad_pin_o <= drive_level(irq_d, irq_polarity);
            irq_or_in1_bad_pin_oe <= 1'b1;
        end else begin
            irq_or_in1_bad_pin_o <= drive_level(in1_bad_status,
                                                bad_input_indicator_polarity);
            irq_or_in1_bad_pin_oe <= in1_bad_route_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            in2_bad_pin_o <= 1'b0;
            in2_bad_pin_oe <= 1'b0;
            unlock_pin_o <= 1'b0;
            unlock_pin_oe <= 1'b0;
            select_or_active_pin_o <= 1'b0;
            select_or_active_pin_oe <= 1'b0;
        end else begin
            in2_bad_pin_o <= drive_level(in2_bad_status, bad_input_indicator_polarity);
            in2_bad_pin_oe <= in2_bad_route_enable;
            unlock_pin_o <= drive_level(unlock_status, unlock_indicator_polarity);
            unlock_pin_oe <= unlock_route_enable;
            select_or_active_pin_o <= drive_level(active_input_status,
                                                  active_input_indicator_polarity);
            select_or_active_pin_oe <= active_route_enable;
        end
    end

    // --------------------------------------------------------------
    // Fast divider
    // --------------------------------------------------------------
    amp_fast_divider u_fast_div (
        .clk(clk),
        .reset(reset),
        .output_fast_divide_select(output_fast_divider_q[`AMP_DIV_SEL_MSB:`AMP_DIV_SEL_LSB]),
        .slow_div1_tick(slow_div1_tick),
        .slow_div2_tick(slow_div2_tick),
        .fast_ratio(fast_ratio)
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_reset_values: assert property (@(posedge clk)
        $past(reset) |-> alarm_pin_polarity_q == `AMP_RST_POLARITY
        && signal_loss_irq_mask_q == `AMP_RST_LOS_MASK
        && offset_lock_irq_mask_q == `AMP_RST_FOS_MASK
        && output_fast_divider_q == `AMP_RST_FAST_DIV)
        else $error("reset values wrong");
    chk_reserved_bits: assert property (@(posedge clk) disable iff (reset)
        (alarm_pin_polarity_q & `AMP_POL_RO_MASK) == (`AMP_RST_POLARITY & `AMP_POL_RO_MASK)
        && (signal_loss_irq_mask_q & `AMP_LOS_RO_MASK) == (`AMP_RST_LOS_MASK & `AMP_LOS_RO_MASK)
        && (offset_lock_irq_mask_q & `AMP_FOS_RO_MASK) == (`AMP_RST_FOS_MASK & `AMP_FOS_RO_MASK)
        && (output_fast_divider_q & `AMP_DIV_RO_MASK) == (`AMP_RST_FAST_DIV & `AMP_DIV_RO_MASK))
        else $error("reserved bits changed");
    chk_irq_unmasked: assert property (@(posedge clk) disable iff (reset)
        (unlock_flag && !unlock_mask) |=> irq_status)
        else $error("unmasked unlock missed");
    chk_irq_clear: assert property (@(posedge clk) disable iff (reset)
        !irq_d |=> !irq_status)
        else $error("irq stuck");
    chk_los_masked: assert property (@(posedge clk) disable iff (reset)
        (in1_signal_loss_mask && in2_signal_loss_mask && xtal_signal_loss_mask
         && in2_freq_offset_mask && in1_freq_offset_mask && unlock_mask) |=> !irq_status)
        else $error("masked flag raised irq");
    // A mask write lands at its edge, so the flag one edge later already sees it.
    sequence s_in2_unmask_write;
        reg_wr && reg_addr == `AMP_ADDR_LOS_MASK && !reg_wdata[`AMP_MSK_IN2_BIT];
    endsequence
    sequence s_in2_loss_seen;
        in2_signal_loss_flag;
    endsequence
    chk_unmask_raises: assert property (@(posedge clk) disable iff (reset)
        s_in2_unmask_write ##1 s_in2_loss_seen |=> irq_status)
        else $error("unmasked loss missed");
    chk_irq_pin_pol: assert property (@(posedge clk) disable iff (reset)
        (irq_route_enable && !irq_polarity) |=> irq_or_in1_bad_pin_o == !$past(irq_d))
        else $error("irq pin polarity");
    chk_irq_pin_drive: assert property (@(posedge clk) disable iff (reset)
        irq_route_enable |=> irq_or_in1_bad_pin_oe
        && irq_or_in1_bad_pin_o == ($past(irq_polarity) ~^ $past(irq_d)))
        else $error("shared pin not showing irq");
    chk_in1_bad_pin: assert property (@(posedge clk) disable iff (reset)
        (!irq_route_enable && in1_bad_route_enable) |=> irq_or_in1_bad_pin_oe
        && irq_or_in1_bad_pin_o
        == ($past(bad_input_indicator_polarity) ~^ $past(in1_bad_status)))
        else $error("shared pin not showing input-one bad");
    chk_in1_float: assert property (@(posedge clk) disable iff (reset)
        (!irq_route_enable && !in1_bad_route_enable) |=> !irq_or_in1_bad_pin_oe)
        else $error("shared pin not floated");
    chk_in2_bad_pin: assert property (@(posedge clk) disable iff (reset)
        in2_bad_route_enable |=> in2_bad_pin_oe
        && in2_bad_pin_o == ($past(bad_input_indicator_polarity) ~^ $past(in2_bad_status)))
        else $error("input-two bad pin wrong");
    chk_unlock_pin: assert property (@(posedge clk) disable iff (reset)
        unlock_route_enable |=> unlock_pin_oe
        && unlock_pin_o == ($past(unlock_indicator_polarity) ~^ $past(unlock_status)))
        else $error("unlock pin wrong");
    chk_unlock_float: assert property (@(posedge clk) disable iff (reset)
        !unlock_route_enable |=> !unlock_pin_oe)
        else $error("unlock pin not floated");
    chk_div_ratio: assert property (@(posedge clk) disable iff (reset)
        fast_ratio == {1'b0, output_fast_divider_q[7:5]} + 4'h4)
        else $error("divide ratio wrong");
    chk_ticks_same: assert property (@(posedge clk) disable iff (reset)
        slow_div1_tick == slow_div2_tick)
        else $error("slow dividers misaligned");
    chk_active_pin: assert property (@(posedge clk) disable iff (reset)
        active_route_enable |=> select_or_active_pin_o
        == ($past(active_input_indicator_polarity) ~^ $past(active_input_status)))
        else $error("active pin wrong");
endmodule
`default_nettype wire

// ### testbench/amp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host processor on the register port
// ----------------------------------------
module amp_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output var logic reg_wr,
    output var logic reg_rd,
    output var amp_pkg::amp_byte_t reg_addr,
    output var amp_pkg::amp_byte_t reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One strobe cycle per access; released lines show the inverse so stale values never match.
    task automatic access(input logic wr, input amp_pkg::amp_byte_t a,
                          input amp_pkg::amp_byte_t d);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// ### testbench/test_alarm_mask_polarity_hs_divider.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_alarm_mask_polarity_hs_divider;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, reset, reg_wr, reg_rd, hit, irq, t1, t2;
    amp_pkg::amp_byte_t reg_addr, reg_wdata, rdata;
    logic [5:0] flg;
    logic [3:0] st, pol;
    logic [3:1] po, poe;
    logic [4:0] rt;
    logic io, ioe;
    amp_pkg::amp_byte_t q[$];
    amp_pkg::amp_byte_t rst_v[4] = '{8'hdf, 8'h1f, 8'h3f, 8'h20};
    amp_pkg::amp_byte_t ro_v[4] = '{8'hf0, 8'hf8, 8'hf8, 8'h1f};
    amp_pkg::amp_byte_t d, exp_v;
    int err_total = 0, checked = 0, cycles = 0, seed = 82, n;
    logic [5:0] m;
    // ----------------------------------------
    // Instances
    // ----------------------------------------
    amp_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    amp_alarm_ctrl dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_hit(hit),
        .in2_signal_loss_flag(flg[5]), .in1_signal_loss_flag(flg[4]),
        .xtal_signal_loss_flag(flg[3]), .in2_freq_offset_flag(flg[2]),
        .in1_freq_offset_flag(flg[1]), .unlock_flag(flg[0]),
        .in1_bad_status(st[0]), .in2_bad_status(st[1]), .unlock_status(st[2]),
        .active_input_status(st[3]), .irq_route_enable(rt[0]),
        .in1_bad_route_enable(rt[1]), .in2_bad_route_enable(rt[2]),
        .unlock_route_enable(rt[3]), .active_route_enable(rt[4]),
        .irq_or_in1_bad_pin_o(io), .irq_or_in1_bad_pin_oe(ioe),
        .in2_bad_pin_o(po[1]), .in2_bad_pin_oe(poe[1]), .unlock_pin_o(po[2]),
        .unlock_pin_oe(poe[2]), .select_or_active_pin_o(po[3]),
        .select_or_active_pin_oe(poe[3]), .irq_status(irq),
        .slow_div1_tick(t1), .slow_div2_tick(t2));
    // ----------------------------------------
    // Clock, timeout and read-data watcher
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    always @(negedge clk) begin
        if (hit === 1'b1) begin
            if (q.size() == 0) begin
                err_total++;
                $display("[FAIL] reg_rdata expected none seen %0h", rdata);
            end else begin
                exp_v = q.pop_front();
                `CHK("reg_rdata", exp_v, rdata)
            end
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wr(input amp_pkg::amp_byte_t a, input amp_pkg::amp_byte_t v);
        host_u.access(1'b1, a, v);
    endtask
    task automatic rd(input amp_pkg::amp_byte_t a, input amp_pkg::amp_byte_t ex);
        q.push_back(ex);
        host_u.access(1'b0, a, 8'h00);
    endtask
    task automatic next_tick(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            `CHK("tick2", t1, t2)
        end while (t1 !== 1'b1 && cnt < 40);
    endtask
    task automatic tally_and_finish();
        if (q.size() != 0) err_total++;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        flg = 6'h00;
        st = 4'h0;
        rt = 5'h00;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        rd(8'h16, 8'hdf);
        rd(8'h17, 8'h1f);
        rd(8'h18, 8'h3f);
        rd(8'h19, 8'h20);
        host_u.access(1'b0, 8'h1a, 8'h00);
        `CHK("unmapped_hit", 1'b0, hit)
        `CHK("unmapped_rdata", 8'h00, rdata)
        $display("test reset_values done");
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            wr(8'h16 + i % 4, d);
            rd(8'h16 + i % 4, (d & ~ro_v[i % 4]) | (rst_v[i % 4] & ro_v[i % 4]));
        end
        $display("test register_access done");
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        wr(8'h1a, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd(8'h16 + i, rst_v[i]);
        end
        $display("test mid_reset done");
        for (int i = 0; i < 6; i++) begin
            m = ~(6'h01 << i);
            wr(8'h17, {5'h00, m[5:3]});
            wr(8'h18, {5'h00, m[2:0]});
            flg = ~(6'h01 << i);
            repeat (3) @(negedge clk);
            `CHK("irq_masked", 1'b0, irq)
            flg = 6'h01 << i;
            repeat (3) @(negedge clk);
            `CHK("irq_unmasked", 1'b1, irq)
        end
        $display("test irq_masks done");
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h00);
        for (int i = 0; i < 24; i++) begin
            pol = $random(seed);
            wr(8'h16, {4'h0, pol});
            {flg, st, rt} = $random(seed);
            repeat (3) @(negedge clk);
            `CHK("irq_level", |flg, irq)
            `CHK("irq_pin_oe", rt[0] | rt[1], ioe)
            if (rt[0]) `CHK("irq_pin", (|flg) ^ ~pol[0], io)
            else if (rt[1]) `CHK("bad1_pin", st[0] ^ ~pol[2], io)
            `CHK("bad2_oe", rt[2], poe[1])
            `CHK("unlock_oe", rt[3], poe[2])
            `CHK("active_oe", rt[4], poe[3])
            if (rt[2]) `CHK("bad2_pin", st[1] ^ ~pol[2], po[1])
            if (rt[3]) `CHK("unlock_pin", st[2] ^ ~pol[1], po[2])
            if (rt[4]) `CHK("active_pin", st[3] ^ ~pol[3], po[3])
        end
        $display("test pin_polarity done");
        for (int s = 0; s < 8; s++) begin
            wr(8'h19, {s[2:0], 5'h00});
            next_tick(n);
            next_tick(n);
            next_tick(n);
            `CHK("tick_gap", s + 4, n)
        end
        $display("test fast_divider done");
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
